// ==== logic/fpi_front_panel.sv ====
// Front panel buttons and indicators with a classic Wishbone register slave
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fpi_params.svh"
module fpi_front_panel
    import fpi_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = `FPI_MS_CYCLES * `FPI_BLINK_HALF_MS,
    parameter int unsigned DEBOUNCE_CYC = `FPI_MS_CYCLES * `FPI_DEBOUNCE_MS,
    parameter int unsigned ACT_FLASH_CYC = `FPI_MS_CYCLES * `FPI_ACT_FLASH_MS,
    parameter int unsigned MS_TICK_CYC = `FPI_MS_CYCLES,
    parameter int unsigned REMOTE_ID_TICKS = `FPI_REMOTE_ID_MS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire fpi_btn_t btn_i,
    input wire logic [3:0] nic_link_i,
    input wire logic [3:0] nic_act_i,
    input wire logic hdd_onboard_act_i,
    input wire logic hdd_addin_act_i,
    output logic [7:0] post_led_o,
    output logic power_led_o,
    output fpi_stat_led_t status_front_o,
    output fpi_stat_led_t status_rear_o,
    output logic id_led_o,
    output logic board_id_led_o,
    output logic hdd_led_o,
    output logic [3:0] nic_led_o,
    output logic power_req_o,
    output logic sleep_req_o,
    output logic sys_reset_o,
    output logic nmi_o,
    output logic halt_o
);

    // Power states in which the platform counts as powered down
    function automatic logic is_down(input logic [2:0] code);
        is_down = (code == FPI_PWR_OFF) || (code == FPI_PWR_S4) || (code == FPI_PWR_S5) || (code > FPI_PWR_S5);
    endfunction : is_down

    logic [3:0] press;
    logic press_pwr;
    logic press_rst;
    logic press_id;
    logic press_nmi;
    logic [3:0] nic_flash;
    logic hdd_flash;
    logic [3:0] link_s1_ff;
    logic [3:0] link_s2_ff;
    logic [7:0] post_code_ff;
    logic [2:0] pwr_ff;
    logic [2:0] health_ff;
    logic sleep_en_ff;
    logic halted_ff;
    logic suppress_ff;
    logic pwr_down_prev_ff;
    logic blink_ff;
    logic [31:0] blink_cnt_ff;
    logic [31:0] tick_cnt_ff;
    logic ms_tick;
    logic [31:0] remote_cnt_ff;
    fpi_id_mode_t id_mode_ff;
    logic wr_en;
    logic remote_req;
    logic halt_clr;
    logic [31:0] rd_data;
    fpi_stat_led_t nxt_status;

    // Debounced presses, one per button
    for (genvar gi = 0; gi < 4; gi++) begin : g_btn
        fpi_debounce #(
            .STABLE_CYC(DEBOUNCE_CYC)
        ) u_deb (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .pin_i(btn_i[gi]),
            .press_o(press[gi])
        );
    end

    assign press_nmi = press[0];
    assign press_id = press[1];
    assign press_rst = press[2];
    assign press_pwr = press[3];

    // One flasher per network port, each from its own pins
    for (genvar gn = 0; gn < 4; gn++) begin : g_nic
        fpi_act_led #(
            .FLASH_CYC(ACT_FLASH_CYC)
        ) u_act (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .act_i(nic_act_i[gn]),
            .flash_o(nic_flash[gn])
        );
    end

    // Either drive controller source lights the drive LED
    fpi_act_led #(
        .FLASH_CYC(ACT_FLASH_CYC)
    ) u_hdd (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .act_i(hdd_onboard_act_i | hdd_addin_act_i),
        .flash_o(hdd_flash)
    );

    // Link levels come from another domain
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            link_s1_ff <= 4'h0;
            link_s2_ff <= 4'h0;
        end else begin
            link_s1_ff <= nic_link_i;
            link_s2_ff <= link_s1_ff;
        end
    end

    // Wishbone: ack one cycle after the request, writes land on the ack edge
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign remote_req = wr_en && (wb_adr_i == `FPI_REG_CTRL) && wb_dat_i[`FPI_CTRL_REMOTE_ID];
    assign halt_clr = wr_en && (wb_adr_i == `FPI_REG_CTRL) && wb_dat_i[`FPI_CTRL_HALT_CLR];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Read mux; unmapped addresses read zero and still ack
    always_comb begin
        rd_data = 32'h0;
        case (wb_adr_i)
            `FPI_REG_CTRL: rd_data[`FPI_CTRL_SLEEP_EN] = sleep_en_ff;
            `FPI_REG_POST: rd_data[7:0] = post_code_ff;
            `FPI_REG_PWR: rd_data[2:0] = pwr_ff;
            `FPI_REG_HEALTH: rd_data[2:0] = health_ff;
            `FPI_REG_STAT: begin
                rd_data[`FPI_STAT_ID_LOCAL] = (id_mode_ff == FPI_ID_LOCAL);
                rd_data[`FPI_STAT_ID_REMOTE] = (id_mode_ff == FPI_ID_REMOTE);
                rd_data[`FPI_STAT_HALTED] = halted_ff;
                rd_data[`FPI_STAT_SUPPRESS] = suppress_ff;
            end
            `FPI_REG_PORTS: rd_data[7:0] = {nic_flash, link_s2_ff};
            default: rd_data = 32'h0;
        endcase
    end

    // Software registers; the last POST code written stays shown
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            post_code_ff <= `FPI_POST_RST;
            pwr_ff <= `FPI_PWR_RST;
            health_ff <= `FPI_HEALTH_RST;
            sleep_en_ff <= 1'b0;
        end else if (wr_en) begin
            case (wb_adr_i)
                `FPI_REG_CTRL: sleep_en_ff <= wb_dat_i[`FPI_CTRL_SLEEP_EN];
                `FPI_REG_POST: post_code_ff <= wb_dat_i[7:0];
                `FPI_REG_PWR: pwr_ff <= wb_dat_i[2:0];
                `FPI_REG_HEALTH: health_ff <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // Free-running half-period counter for the power, status and identify blinking; activity flashers time themselves
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= 1'b0;
        end else if (blink_cnt_ff >= BLINK_HALF_CYC - 1) begin
            blink_cnt_ff <= 32'h0;
            blink_ff <= !blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 32'h1;
        end
    end

    // Millisecond prescaler keeps the long timer counter small in toggles
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_ff <= 32'h0;
        end else if (ms_tick) begin
            tick_cnt_ff <= 32'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end

    assign ms_tick = (tick_cnt_ff >= MS_TICK_CYC - 1);

    // Identify mode: local press toggles, remote runs for fixed time
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            id_mode_ff <= FPI_ID_OFF;
            remote_cnt_ff <= 32'h0;
        end else if (press_id) begin
            remote_cnt_ff <= 32'h0;
            unique case (id_mode_ff)
                FPI_ID_OFF: id_mode_ff <= FPI_ID_LOCAL;
                FPI_ID_LOCAL: id_mode_ff <= FPI_ID_OFF;
                FPI_ID_REMOTE: id_mode_ff <= FPI_ID_OFF;
            endcase
        end else if (remote_req) begin
            id_mode_ff <= FPI_ID_REMOTE;
            remote_cnt_ff <= 32'h0;
        end else if (id_mode_ff == FPI_ID_REMOTE && ms_tick) begin
            if (remote_cnt_ff >= REMOTE_ID_TICKS - 1) begin
                id_mode_ff <= FPI_ID_OFF;
                remote_cnt_ff <= 32'h0;
            end else begin
                remote_cnt_ff <= remote_cnt_ff + 32'h1;
            end
        end
    end

    // Halt held until reset press or software clear; an NMI press wins a same-cycle clear
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            halted_ff <= 1'b0;
        end else if (press_nmi) begin
            halted_ff <= 1'b1;
        end else if (press_rst || halt_clr) begin
            halted_ff <= 1'b0;
        end
    end

    // A normal platform going down darkens status; other states are kept
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_down_prev_ff <= 1'b1;
            suppress_ff <= 1'b0;
        end else begin
            pwr_down_prev_ff <= is_down(pwr_ff);
            if (!pwr_down_prev_ff && is_down(pwr_ff) && health_ff == FPI_HL_READY) begin
                suppress_ff <= 1'b1;
            end else if (!is_down(pwr_ff) || (wr_en && wb_adr_i == `FPI_REG_HEALTH)) begin
                suppress_ff <= 1'b0;
            end
        end
    end

    // Status colour from health
    always_comb begin
        nxt_status = '0;
        if (!suppress_ff) begin
            case (health_ff)
                FPI_HL_READY: nxt_status.green = 1'b1;
                FPI_HL_DEGRADED: nxt_status.green = blink_ff;
                FPI_HL_CRIT: nxt_status.amber = 1'b1;
                FPI_HL_NONCRIT: nxt_status.amber = blink_ff;
                default: nxt_status = '0;
            endcase
        end
    end

    // Registered indicators and request pulses
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            post_led_o <= 8'h00;
            power_led_o <= 1'b0;
            status_front_o <= '0;
            id_led_o <= 1'b0;
            hdd_led_o <= 1'b0;
            nic_led_o <= 4'h0;
            power_req_o <= 1'b0;
            sleep_req_o <= 1'b0;
            sys_reset_o <= 1'b0;
            nmi_o <= 1'b0;
        end else begin
            post_led_o <= post_code_ff;
            power_led_o <= (pwr_ff == FPI_PWR_S0) || (pwr_ff == FPI_PWR_ON)
                || (pwr_ff == FPI_PWR_SLEEP && blink_ff);
            status_front_o <= nxt_status;
            id_led_o <= (id_mode_ff == FPI_ID_LOCAL) || (id_mode_ff == FPI_ID_REMOTE && blink_ff);
            hdd_led_o <= hdd_flash;
            nic_led_o <= link_s2_ff & ~nic_flash;
            power_req_o <= press_pwr && !sleep_en_ff;
            sleep_req_o <= press_pwr && sleep_en_ff;
            sys_reset_o <= press_rst;
            nmi_o <= press_nmi;
        end
    end

    assign status_rear_o = status_front_o;
    assign board_id_led_o = id_led_o;
    assign halt_o = halted_ff;

    // Checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_nmi_press;
        press_nmi;
    endsequence
    sequence s_halted;
        nmi_o && halt_o ##1 !nmi_o && halt_o;
    endsequence
    property p_nmi_halt;
        s_nmi_press |=> s_halted;
    endproperty
    a_nmi_halt: assert property (p_nmi_halt) else $error("NMI press did not halt");

    property p_post_show;
        wr_en && wb_adr_i == `FPI_REG_POST |=> ##1 post_led_o == $past(wb_dat_i[7:0], 2);
    endproperty
    a_post_show: assert property (p_post_show) else $error("POST code not shown");

    property p_status_same;
        status_rear_o == status_front_o && board_id_led_o == id_led_o;
    endproperty
    a_status_same: assert property (p_status_same) else $error("Front and rear differ");

    property p_pwr_req;
        press_pwr |=> power_req_o == !$past(sleep_en_ff) && sleep_req_o == $past(sleep_en_ff);
    endproperty
    a_pwr_req: assert property (p_pwr_req) else $error("Power press misrouted");

    property p_reset_req;
        press_rst |=> sys_reset_o ##1 !halt_o || $past(press_nmi);
    endproperty
    a_reset_req: assert property (p_reset_req) else $error("Reset press not forwarded");

    property p_nic_dark;
        !link_s2_ff[0] |=> !nic_led_o[0];
    endproperty
    a_nic_dark: assert property (p_nic_dark) else $error("NIC LED lit without link");

    property p_power_off;
        is_down(pwr_ff) |=> !power_led_o;
    endproperty
    a_power_off: assert property (p_power_off) else $error("Power LED lit while down");

    property p_id_cancel;
        press_id && id_mode_ff == FPI_ID_REMOTE |=> id_mode_ff == FPI_ID_OFF ##2 !id_led_o || id_mode_ff != FPI_ID_OFF;
    endproperty
    a_id_cancel: assert property (p_id_cancel) else $error("Local press did not cancel");

    property p_wb_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("Ack not single cycle");

    property p_green_down;
        !pwr_down_prev_ff && is_down(pwr_ff) && health_ff == FPI_HL_READY |=> ##1 !status_front_o.green;
    endproperty
    a_green_down: assert property (p_green_down) else $error("Green kept at power-down");

endmodule : fpi_front_panel
`default_nettype wire

// ==== shared/fpi_params.svh ====
// Offsets, field positions, reset values and timing figures of the front panel block
`ifndef FPI_PARAMS_SVH
`define FPI_PARAMS_SVH

// System clock rate and the millisecond it is counted in
`define FPI_CLK_HZ 50000000
`define FPI_MS_CYCLES (`FPI_CLK_HZ / 1000)

// Timing figures in their own units
`define FPI_BLINK_HALF_MS 500
`define FPI_DEBOUNCE_MS 10
`define FPI_ACT_FLASH_MS 40
`define FPI_REMOTE_ID_S 15
`define FPI_REMOTE_ID_MS (`FPI_REMOTE_ID_S * 1000)

// Register byte offsets
`define FPI_REG_CTRL 8'h00
`define FPI_REG_POST 8'h04
`define FPI_REG_PWR 8'h08
`define FPI_REG_HEALTH 8'h0C
`define FPI_REG_STAT 8'h10
`define FPI_REG_PORTS 8'h14

// Control register fields
`define FPI_CTRL_SLEEP_EN 0
`define FPI_CTRL_REMOTE_ID 1
`define FPI_CTRL_HALT_CLR 2

// Status register fields
`define FPI_STAT_ID_LOCAL 0
`define FPI_STAT_ID_REMOTE 1
`define FPI_STAT_HALTED 2
`define FPI_STAT_SUPPRESS 3

// Reset values
`define FPI_POST_RST 8'h00
`define FPI_PWR_RST 3'h0
`define FPI_HEALTH_RST 3'h0

`endif

// ==== shared/fpi_pkg.sv ====
// Types shared by the front panel indicator block
`default_nettype none
package fpi_pkg;

    // Platform power state as written by the management controller
    typedef enum logic [2:0] {
        FPI_PWR_OFF,
        FPI_PWR_ON,
        FPI_PWR_S0,
        FPI_PWR_SLEEP,
        FPI_PWR_S4,
        FPI_PWR_S5
    } fpi_pwr_t;

    // Platform health as written by the management controller
    typedef enum logic [2:0] {
        FPI_HL_STANDBY,
        FPI_HL_READY,
        FPI_HL_DEGRADED,
        FPI_HL_NONCRIT,
        FPI_HL_CRIT
    } fpi_health_t;

    // Identify indicator modes
    typedef enum logic [1:0] {
        FPI_ID_OFF,
        FPI_ID_LOCAL,
        FPI_ID_REMOTE
    } fpi_id_mode_t;

    // Front panel buttons, high while pressed
    typedef struct packed {
        logic pwr;
        logic rst;
        logic ident;
        logic nmi;
    } fpi_btn_t;

    // Bi-colour status indicator
    typedef struct packed {
        logic green;
        logic amber;
    } fpi_stat_led_t;

endpackage : fpi_pkg
`default_nettype wire

// ==== logic/fpi_debounce.sv ====
// Button synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
`default_nettype none
module fpi_debounce #(
    parameter int unsigned STABLE_CYC = 500000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic press_o
);

    logic sync1_ff;
    logic sync2_ff;
    logic stable_ff;
    logic [31:0] cnt_ff;

    // Two flops before anything looks at the pin
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
        end
    end

    // Level must hold for the whole window; any bounce restarts it
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 32'h0;
            stable_ff <= 1'b0;
        end else if (sync2_ff == stable_ff) begin
            cnt_ff <= 32'h0;
        end else if (cnt_ff >= STABLE_CYC - 1) begin
            cnt_ff <= 32'h0;
            stable_ff <= sync2_ff;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // One pulse on the accepted press edge
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            press_o <= 1'b0;
        end else begin
            press_o <= (sync2_ff != stable_ff) && sync2_ff && (cnt_ff >= STABLE_CYC - 1);
        end
    end

endmodule : fpi_debounce
`default_nettype wire

// ==== logic/fpi_act_led.sv ====
// Activity flasher: each burst of traffic gives one dark/lit blink
`timescale 1ns/1ps
`default_nettype none
module fpi_act_led #(
    parameter int unsigned FLASH_CYC = 2000000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic act_i,
    output logic flash_o
);

    typedef enum logic [1:0] {
        ACT_IDLE,
        ACT_FLASH,
        ACT_GAP
    } fpi_act_st_t;

    fpi_act_st_t st_ff;
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic pend_ff;
    logic [31:0] cnt_ff;
    logic act_edge;

    // Synchronise, third flop only for edge detect
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= act_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign act_edge = s2_ff && !s3_ff;

    // Traffic seen during a blink is kept so heavy load blinks back to back
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= ACT_IDLE;
            cnt_ff <= 32'h0;
            pend_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                ACT_IDLE: begin
                    cnt_ff <= 32'h0;
                    if (act_edge || pend_ff) begin
                        st_ff <= ACT_FLASH;
                        pend_ff <= 1'b0;
                    end
                end
                ACT_FLASH: begin
                    pend_ff <= pend_ff | act_edge;
                    cnt_ff <= (cnt_ff >= FLASH_CYC - 1) ? 32'h0 : cnt_ff + 32'h1;
                    if (cnt_ff >= FLASH_CYC - 1) begin
                        st_ff <= ACT_GAP;
                    end
                end
                ACT_GAP: begin
                    pend_ff <= pend_ff | act_edge;
                    cnt_ff <= (cnt_ff >= FLASH_CYC - 1) ? 32'h0 : cnt_ff + 32'h1;
                    if (cnt_ff >= FLASH_CYC - 1) begin
                        st_ff <= ACT_IDLE;
                    end
                end
            endcase
        end
    end

    assign flash_o = (st_ff == ACT_FLASH);

endmodule : fpi_act_led
`default_nettype wire

// ==== testbench/fpi_mgmt_model.sv ====
// Management controller and boot firmware model: register master of the panel
`timescale 1ns/1ps
`default_nettype none
`include "fpi_params.svh"
module fpi_mgmt_model (
    input wire logic mclk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [3:0] sel_o,
    output logic [7:0] adr_o,
    output logic [31:0] dat_o
);
    // Bus idle at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        sel_o = 4'h0;
        adr_o = 8'h00;
        dat_o = 32'h0;
    end
    // One classic cycle held until ack; released data is inverted so stale values never pass
    task automatic xfer(input logic we, input logic [3:0] sel, input logic [7:0] adr, input logic [7:0] wd,
        output logic [7:0] rd);
        @(posedge mclk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        sel_o <= sel;
        adr_o <= adr;
        dat_o <= {24'h0, wd};
        do @(posedge mclk_i); while (ack_i !== 1'b1);
        rd = dat_i[7:0];
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        dat_o <= ~{24'h0, wd};
    endtask : xfer
    // Firmware posts a code as each configuration routine starts
    task automatic post(input logic [7:0] code);
        logic [7:0] unused;
        xfer(1'b1, 4'hF, `FPI_REG_POST, code, unused);
    endtask : post
endmodule : fpi_mgmt_model
`default_nettype wire

// ==== testbench/fpi_front_panel_tb_top.sv ====
// Self-checking bench for the front panel indicator block
`timescale 1ns/1ps
`default_nettype none
`include "fpi_params.svh"
module fpi_front_panel_tb_top;
    localparam int DEB = 4;
    localparam int PWR_EXP[8] = '{0, 1, 1, 2, 0, 0, 0, 0};
    localparam int GRN[8] = '{0, 1, 2, 0, 0, 0, 0, 0};
    localparam int AMB[8] = '{0, 0, 0, 2, 1, 0, 0, 0};
    logic clk;
    logic rst;
    logic cyc, stb, we, ack, pled, id, bid, hdd, preq, sreq, srst, nmi, halt, hdd_a, hdd_b;
    logic [7:0] adr, post_led, rd;
    logic [31:0] wdat, rdat;
    logic [3:0] link, act, nic, sel;
    fpi_pkg::fpi_btn_t btn;
    fpi_pkg::fpi_stat_led_t sf, sr;
    int bad_count = 0;
    int samples_checked = 0;
    int hi[6];

    fpi_front_panel #(.BLINK_HALF_CYC(8), .DEBOUNCE_CYC(DEB), .ACT_FLASH_CYC(4), .MS_TICK_CYC(4),
        .REMOTE_ID_TICKS(12)) fpi_front_panel_i (.mclk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .btn_i(btn), .nic_link_i(link), .nic_act_i(act), .hdd_onboard_act_i(hdd_a), .hdd_addin_act_i(hdd_b),
        .post_led_o(post_led), .power_led_o(pled), .status_front_o(sf), .status_rear_o(sr), .id_led_o(id),
        .board_id_led_o(bid), .hdd_led_o(hdd), .nic_led_o(nic), .power_req_o(preq), .sleep_req_o(sreq),
        .sys_reset_o(srst), .nmi_o(nmi), .halt_o(halt));
    fpi_mgmt_model fpi_mgmt_model_i (.mclk_i(clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        fpi_mgmt_model_i.xfer(1'b1, 4'hF, a, d, rd);
    endtask : wr

    // 0 dark, 1 steady, 2 blinking
    function automatic int cls(input int c, input int n);
        return (c == 0) ? 0 : ((c == n) ? 1 : 2);
    endfunction : cls

    // Let outputs settle, then count lit cycles of the power, status, identify, drive and first NIC indicators
    task automatic watch(input int n);
        repeat (3) @(negedge clk);
        hi = '{default: 0};
        repeat (n) begin
            @(negedge clk);
            hi[0] += int'(pled);
            hi[1] += int'(sf.green);
            hi[2] += int'(sf.amber);
            hi[3] += int'(id);
            hi[4] += int'(hdd);
            hi[5] += int'(nic[0]);
            chk("rear copies", {sf, id}, {sr, bid});
        end
    endtask : watch

    // Hold a button past the debounce window, release; expect exactly one request cycle, or none when none is expected
    task automatic press(input int b, input logic [3:0] exp);
        logic [3:0] seen;
        int n;
        seen = 4'h0;
        n = 0;
        for (int k = 0; k < 2 * DEB + 20; k++) begin
            @(posedge clk);
            btn <= (k < DEB + 10) ? fpi_pkg::fpi_btn_t'(4'h1 << b) : fpi_pkg::fpi_btn_t'(4'h0);
            @(negedge clk);
            seen |= {preq, sreq, srst, nmi};
            n += int'(preq | sreq | srst | nmi);
        end
        chk("request pulses", {seen, 4'(n)}, {exp, 4'(exp != 4'h0)});
    endtask : press

    task automatic t_post();
        fpi_mgmt_model_i.post(8'hA5);
        repeat (3) @(negedge clk);
        chk("post leds", 8'hA5, post_led);
        fpi_mgmt_model_i.post(8'h3C);
        // Low byte lane disabled: the write must not land
        fpi_mgmt_model_i.xfer(1'b1, 4'hE, `FPI_REG_POST, 8'h5A, rd);
        fpi_mgmt_model_i.xfer(1'b0, 4'hF, `FPI_REG_POST, 8'h00, rd);
        chk("post readback", 8'h3C, rd);
        fpi_mgmt_model_i.xfer(1'b0, 4'hF, 8'h40, 8'h00, rd);
        chk("unmapped read", 8'h00, rd);
        chk("post leds", 8'h3C, post_led);
    endtask : t_post

    task automatic t_buttons();
        press(3, 4'b1000);
        wr(`FPI_REG_CTRL, 8'h01);
        press(3, 4'b0100);
        wr(`FPI_REG_CTRL, 8'h00);
        press(0, 4'b0001);
        chk("halt", 1'b1, halt);
        press(2, 4'b0010);
        chk("halt after reset press", 1'b0, halt);
        press(0, 4'b0001);
        wr(`FPI_REG_CTRL, 8'h04);
        repeat (2) @(negedge clk);
        chk("halt cleared", 1'b0, halt);
    endtask : t_buttons

    task automatic t_ident();
        press(1, 4'h0);
        chk("id on", 2'b11, {id, bid});
        press(1, 4'h0);
        chk("id off", 2'b00, {id, bid});
        wr(`FPI_REG_CTRL, 8'h02);
        watch(12);
        chk("remote id blink", 2, cls(hi[3], 12));
        repeat (40) @(negedge clk);
        watch(16);
        chk("remote id expired", 0, hi[3]);
        wr(`FPI_REG_CTRL, 8'h02);
        press(1, 4'h0);
        watch(24);
        chk("remote id cancelled", 0, hi[3]);
    endtask : t_ident

    // Power LED per state code, then every status code with power up
    task automatic t_states();
        for (int s = 0; s < 8; s++) begin
            wr(`FPI_REG_PWR, 8'(s));
            watch(16);
            chk("power led", PWR_EXP[s], cls(hi[0], 16));
        end
        wr(`FPI_REG_PWR, 8'h02);
        for (int h = 0; h < 8; h++) begin
            wr(`FPI_REG_HEALTH, 8'(h));
            watch(16);
            chk("status green", GRN[h], cls(hi[1], 16));
            chk("status amber", AMB[h], cls(hi[2], 16));
        end
        wr(`FPI_REG_HEALTH, 8'h01);
        wr(`FPI_REG_PWR, 8'h05);
        watch(8);
        chk("green at power down", 0, hi[1]);
        wr(`FPI_REG_HEALTH, 8'h04);
        wr(`FPI_REG_PWR, 8'h02);
        wr(`FPI_REG_PWR, 8'h05);
        watch(8);
        chk("amber kept at power down", 8, hi[2]);
    endtask : t_states

    task automatic t_ports();
        @(posedge clk);
        link <= 4'b0101;
        watch(8);
        chk("link leds", 4'b0101, nic);
        @(posedge clk);
        act <= 4'b0011;
        hdd_a <= 1'b1;
        watch(16);
        chk("nic flash", 2, cls(hi[5], 16));
        chk("onboard drive flash", 2, cls(hi[4], 16));
        chk("other ports steady", 4'b0101, nic);
        // Drop the first source long enough that the second gives a fresh edge
        @(posedge clk);
        hdd_a <= 1'b0;
        repeat (4) @(posedge clk);
        hdd_b <= 1'b1;
        watch(16);
        chk("addin drive flash", 2, cls(hi[4], 16));
        @(posedge clk);
        hdd_b <= 1'b0;
        link <= 4'h0;
        watch(16);
        chk("idle drive", 0, hi[4]);
        chk("idle ports", 4'h0, nic);
    endtask : t_ports

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // Main sequence
    initial begin
        rst = 1'b1;
        btn = '0;
        link = 4'h0;
        act = 4'h0;
        hdd_a = 1'b0;
        hdd_b = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_post();
        t_buttons();
        t_ident();
        t_states();
        t_ports();
        results();
    end

    // Watchdog well past the expected run
    initial begin
        repeat (8000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule : fpi_front_panel_tb_top
`default_nettype wire
